// >>> verification/qrsbp_monitor.sv
// Checker on the link between controller and burst SRAM
`timescale 1ns/1ps
module qrsbp_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Link
	input wire logic read_port_select_n,
	input wire logic write_port_select_n,
	input wire logic [qrsbp_pkg::ADDR_W-1:0] addr,
	input wire logic [qrsbp_pkg::DATA_W-1:0] write_input_bus,
	input wire logic [qrsbp_pkg::LANES-1:0] byte_lane_mask_n,
	input wire logic [qrsbp_pkg::DATA_W-1:0] read_output_bus,
	input wire logic read_output_oe,
	input wire logic read_output_valid,
	input wire logic ref_pos_phase,
	// Strap
	input wire logic delay_loop_disable
);
	logic [3:0] idle_r, idle_nxt;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence rd_go; ref_pos_phase && !read_port_select_n; endsequence
	sequence wr_go; ref_pos_phase && !write_port_select_n; endsequence
	sequence beats4; read_output_valid [*4]; endsequence
	sequence mask_idle;
		byte_lane_mask_n == qrsbp_pkg::MASK_NONE;
	endsequence
	// Saturates so a long idle spell never wraps
	always_comb begin
		idle_nxt = (idle_r == 4'hf) ? idle_r : idle_r + 4'h1;
		if (ref_pos_phase && !read_port_select_n)
			idle_nxt = 4'h0;
	end
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			idle_r <= 4'hf;
		else
			idle_r <= idle_nxt;
	end
	read_lat_a: assert property (rd_go ##0 !delay_loop_disable
		|-> ##4 beats4) else $error("read beats late or short");
	read_nodll_a: assert property (rd_go ##0 delay_loop_disable
		|-> ##3 beats4) else $error("no-loop read beats wrong");
	valid_run_a: assert property (
		$rose(read_output_valid) |-> beats4) else $error("burst not 4 beats");
	read_space_a: assert property (
		rd_go |-> ##2 !(ref_pos_phase && !read_port_select_n))
		else $error("reads on consecutive edges");
	write_space_a: assert property (
		wr_go |-> ##2 !(ref_pos_phase && !write_port_select_n))
		else $error("writes on consecutive edges");
	phase_a: assert property ($past(arst_n)
		|-> ref_pos_phase != $past(ref_pos_phase)) else $error("phase stuck");
	oe_valid_a: assert property (
		read_output_valid |-> read_output_oe) else $error("beat while undriven");
	idle_oe_a: assert property (
		idle_r >= 4'hc |-> !read_output_oe) else $error("bus driven when idle");
	write_frame_a: assert property (
		wr_go |-> ##1 mask_idle ##5 mask_idle)
		else $error("write beats outside their slots");
endmodule

// >>> verification/quad_rate_sram_burst_port_tb.sv
// Self-checking bench: controller and device joined by the link
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	err_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module quad_rate_sram_burst_port_tb;
	logic clock, arst_n, dll_off, full, req_valid, req_write, req_ready;
	logic wr_data_take, rd_data_valid, clk_stop;
	logic [qrsbp_pkg::ADDR_W-1:0] req_addr, a;
	logic [qrsbp_pkg::DATA_W-1:0] wr_data, rd_data;
	logic [qrsbp_pkg::DATA_W-1:0] mem [qrsbp_pkg::DEPTH];
	logic [qrsbp_pkg::LANES-1:0] wr_mask_n;
	logic [qrsbp_pkg::DATA_W-1:0] exp_q [$], wire_q [$];
	logic [qrsbp_pkg::ADDR_W-1:0] wa_q [$];
	int err_count, n_checks, cyc, wb;
	int seed = 32'h6476;
	qrsbp_if lk();
	qrsbp_device qrsbp_device_inst (.clock(clock), .arst_n(arst_n),
		.link(lk.device), .delay_loop_disable(dll_off));
	qrsbp_controller qrsbp_controller_inst (.clock(clock), .arst_n(arst_n),
		.link(lk.controller), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_ready(req_ready), .wr_data(wr_data),
		.wr_mask_n(wr_mask_n), .wr_data_take(wr_data_take),
		.rd_data(rd_data), .rd_data_valid(rd_data_valid));
	qrsbp_monitor qrsbp_monitor_inst (.clock(clock), .arst_n(arst_n),
		.read_port_select_n(lk.read_port_select_n),
		.write_port_select_n(lk.write_port_select_n), .addr(lk.addr),
		.write_input_bus(lk.write_input_bus),
		.byte_lane_mask_n(lk.byte_lane_mask_n),
		.read_output_bus(lk.read_output_bus),
		.read_output_oe(lk.read_output_oe),
		.read_output_valid(lk.read_output_valid),
		.ref_pos_phase(lk.ref_pos_phase), .delay_loop_disable(dll_off));
	task automatic finish_test();
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Holds the request until ready is seen at a rising edge
	task automatic op(input logic w, input int b);
		req_valid = 1'b1;
		req_write = w;
		req_addr = qrsbp_pkg::ADDR_W'(b);
		@(posedge clock);
		while (req_ready !== 1'b1)
			@(posedge clock);
		@(negedge clock);
	endtask
	task automatic gap();
		req_valid = 1'b0;
		repeat (12) @(negedge clock);
	endtask
	// Clock parked low mid-burst: outputs must not move
	task automatic park();
		logic [qrsbp_pkg::DATA_W-1:0] held;
		logic held_oe;
		repeat (4) @(negedge clock);
		held = lk.read_output_bus;
		held_oe = lk.read_output_oe;
		clk_stop = 1'b1;
		// Off the clock loop's ticks, so the restart has no race
		#97;
		`CHK("park_q", held, lk.read_output_bus)
		`CHK("park_oe", held_oe, lk.read_output_oe)
		clk_stop = 1'b0;
	endtask
	// Reads and writes use disjoint areas while mixed: no forwarding
	task automatic pass_run(input logic off);
		logic w;
		arst_n = 1'b0;
		dll_off = off;
		full = 1'b1;
		repeat (12) @(negedge clock);
		`CHK("oe", 1'b0, lk.read_output_oe)
		arst_n = 1'b1;
		for (int b = 0; b < 128; b += 4)
			op(1'b1, b);
		gap();
		full = 1'b0;
		repeat (40) begin
			w = 1'($random(seed));
			if (w)
				op(1'b1, 64 + {$random(seed)} % 61);
			else
				op(1'b0, {$random(seed)} % 61);
		end
		gap();
		repeat (16) op(1'b0, 64 + {$random(seed)} % 61);
		park();
		gap();
		`CHK("drain", 0, exp_q.size())
	endtask
	initial begin
		clock = 1'b0;
		clk_stop = 1'b0;
		forever #5
			if (!clk_stop)
				clock = ~clock;
	end
	always @(negedge clock) begin
		wr_data = qrsbp_pkg::DATA_W'($random(seed));
		wr_mask_n = full ? '0 : qrsbp_pkg::LANES'($random(seed));
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			finish_test();
		end
		if (req_valid && req_ready && req_write)
			wa_q.push_back(req_addr);
		if (req_valid && req_ready && !req_write)
			for (int k = 0; k < 4; k++) begin
				exp_q.push_back(mem[8'(req_addr + k)]);
				wire_q.push_back(mem[8'(req_addr + k)]);
			end
		if (wr_data_take === 1'b1) begin
			a = wa_q[0] + wb[7:0];
			for (int l = 0; l < qrsbp_pkg::LANES; l++)
				if (!wr_mask_n[l])
					mem[a][l*9 +: 9] = wr_data[l*9 +: 9];
			wb = (wb + 1) % 4;
			if (wb == 0)
				void'(wa_q.pop_front());
		end
		if (lk.read_output_valid === 1'b1) begin
			`CHK("bus", wire_q[0], lk.read_output_bus)
			void'(wire_q.pop_front());
		end
		if (rd_data_valid === 1'b1) begin
			`CHK("rd_data", exp_q[0], rd_data)
			void'(exp_q.pop_front());
		end
	end
	initial begin
		arst_n = 1'b0;
		dll_off = 1'b0;
		full = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		wr_data = '0;
		wr_mask_n = '1;
		pass_run(1'b0);
		pass_run(1'b1);
		finish_test();
	end
endmodule

// >>> verilog/qrsbp_controller.sv
// Controller end: issues read and write bursts to the SRAM
`timescale 1ns/1ps
module qrsbp_controller (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Link
	qrsbp_if.controller link,
	// User request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [qrsbp_pkg::ADDR_W-1:0] req_addr,
	output logic req_ready,
	// User write data, one word per beat
	input wire logic [qrsbp_pkg::DATA_W-1:0] wr_data,
	input wire logic [qrsbp_pkg::LANES-1:0] wr_mask_n,
	output logic wr_data_take,
	// User read data
	output logic [qrsbp_pkg::DATA_W-1:0] rd_data,
	output logic rd_data_valid
);
	logic phase_r, phase_nxt;
	logic rsel_n_r, rsel_n_nxt, wsel_n_r, wsel_n_nxt;
	logic [qrsbp_pkg::ADDR_W-1:0] addr_r, addr_nxt;
	logic last_rd_r, last_rd_nxt, last_wr_r, last_wr_nxt;
	logic [2:0] wcnt_r, wcnt_nxt;
	logic [qrsbp_pkg::DATA_W-1:0] d_r, d_nxt, rd_r, rd_nxt;
	logic [qrsbp_pkg::LANES-1:0] m_r, m_nxt;
	logic rv_r, rv_nxt;
	logic issue;

	// Same type never on consecutive positive edges
	assign req_ready = !phase_r && !(req_write ? last_wr_r : last_rd_r) &&
		wcnt_r <= 3'h1;
	assign issue = req_valid && req_ready;
	// Beats launch one edge before the device's t+1 and t+2 samples
	assign wr_data_take = wcnt_r >= 3'h2 && wcnt_r <= 3'h5;

	always_comb begin
		phase_nxt = !phase_r;
		rsel_n_nxt = rsel_n_r;
		wsel_n_nxt = wsel_n_r;
		addr_nxt = addr_r;
		last_rd_nxt = last_rd_r;
		last_wr_nxt = last_wr_r;
		wcnt_nxt = wcnt_r;
		d_nxt = d_r;
		m_nxt = qrsbp_pkg::MASK_NONE;
		rd_nxt = rd_r;
		rv_nxt = 1'b0;
		if (!phase_r) begin
			rsel_n_nxt = !(issue && !req_write);
			wsel_n_nxt = !(issue && req_write);
			last_rd_nxt = issue && !req_write;
			last_wr_nxt = issue && req_write;
			if (issue)
				addr_nxt = req_addr;
		end
		// Beats follow the select by one edge pair
		if (issue && req_write)
			wcnt_nxt = 3'h6;
		else if (wcnt_r != 3'h0)
			wcnt_nxt = wcnt_r - 3'h1;
		if (wr_data_take) begin
			d_nxt = wr_data;
			m_nxt = wr_mask_n; // Per-beat mask
		end
		if (link.read_output_valid) begin
			rd_nxt = link.read_output_bus;
			rv_nxt = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			phase_r <= 1'b0;
			rsel_n_r <= 1'b1;
			wsel_n_r <= 1'b1;
			addr_r <= qrsbp_pkg::ADDR_RST;
			last_rd_r <= 1'b0;
			last_wr_r <= 1'b0;
			wcnt_r <= 3'h0;
			d_r <= qrsbp_pkg::DATA_RST;
			m_r <= qrsbp_pkg::MASK_NONE;
			rd_r <= qrsbp_pkg::DATA_RST;
			rv_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			rsel_n_r <= rsel_n_nxt;
			wsel_n_r <= wsel_n_nxt;
			addr_r <= addr_nxt;
			last_rd_r <= last_rd_nxt;
			last_wr_r <= last_wr_nxt;
			wcnt_r <= wcnt_nxt;
			d_r <= d_nxt;
			m_r <= m_nxt;
			rd_r <= rd_nxt;
			rv_r <= rv_nxt;
		end
	end

	// One clock times both directions: single clock mode only
	assign link.ref_pos_phase = phase_r;
	assign link.read_port_select_n = rsel_n_r;
	assign link.write_port_select_n = wsel_n_r;
	assign link.addr = addr_r;
	assign link.write_input_bus = d_r;
	assign link.byte_lane_mask_n = m_r;
	assign rd_data = rd_r;
	assign rd_data_valid = rv_r;
endmodule

// >>> verilog/qrsbp_device.sv
// Device end: burst SRAM with separate read and write ports
// Functional notes
// - Write select latches address; data at t+1,t+2
// - Read select latches address; data t+1 to t+3
// - Deselected after reset, read bus undriven
// - Stopped clock keeps previous output state
// - Burst walks A, A+1, A+2, A+3
// - Data captured and driven on both edges
// - Select after an initiating edge is ignored
// - Back-to-back same-type request is ignored
// - Two-lane mask gates bits 8..0, 17..9
// - Four-lane mask gates four nine-bit lanes (this build has two lanes only, LANES = 2)
// - Masks sampled separately for every data word
// - Single clock mode is a fixed strap
// - Loop disabled gives one cycle read latency
`timescale 1ns/1ps
module qrsbp_device (
	// Clock and reset; one tick per data edge, phase on the link
	input wire logic clock,
	input wire logic arst_n,
	// Link
	qrsbp_if.device link,
	// Strap
	input wire logic delay_loop_disable
);
	logic [qrsbp_pkg::DATA_W-1:0] mem [qrsbp_pkg::DEPTH];
	logic wr_act_r, wr_act_nxt, rd_act_r, rd_act_nxt;
	logic [1:0] wr_beat_r, wr_beat_nxt, rd_beat_r, rd_beat_nxt;
	logic [qrsbp_pkg::ADDR_W-1:0] wr_addr_r, wr_addr_nxt;
	logic [qrsbp_pkg::ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
	logic [2:0] rd_wait_r, rd_wait_nxt;
	logic wr_lock_r, wr_lock_nxt, rd_lock_r, rd_lock_nxt;
	// Started bursts wait here until their start edge; a busy burst does not delay them
	logic wr_pend_r, wr_pend_nxt, rd_pend_r, rd_pend_nxt;
	logic [qrsbp_pkg::ADDR_W-1:0] wr_paddr_r, wr_paddr_nxt;
	logic [qrsbp_pkg::ADDR_W-1:0] rd_paddr_r, rd_paddr_nxt;
	logic [qrsbp_pkg::DATA_W-1:0] q_r, q_nxt;
	logic oe_r, oe_nxt, vld_r, vld_nxt;
	logic nodll_r;
	logic wr_go, rd_go;

	// Burst address: base plus beat offset, carrying past the four-word group
	function automatic logic [qrsbp_pkg::ADDR_W-1:0] burst_addr(
		input logic [qrsbp_pkg::ADDR_W-1:0] base, input logic [1:0] beat);
		burst_addr = base + {{(qrsbp_pkg::ADDR_W-2){1'b0}}, beat};
	endfunction

	// Lane merge: a low mask bit takes the new lane
	function automatic logic [qrsbp_pkg::DATA_W-1:0] merge(
		input logic [qrsbp_pkg::DATA_W-1:0] old_w,
		input logic [qrsbp_pkg::DATA_W-1:0] new_w,
		input logic [qrsbp_pkg::LANES-1:0] mask_n);
		merge = old_w;
		for (int i = 0; i < qrsbp_pkg::LANES; i++) begin
			if (!mask_n[i])
				merge[i*qrsbp_pkg::LANE_W +: qrsbp_pkg::LANE_W] =
					new_w[i*qrsbp_pkg::LANE_W +: qrsbp_pkg::LANE_W];
		end
	endfunction

	// Strap pin passes three flops; taken once, when the last two agree
	// Reads started before it settles use the loop latency
	logic strap_done_r, strap_done_nxt, nodll_nxt;
	logic [2:0] dll_sync_r, dll_sync_nxt, fill_r, fill_nxt;
	always_comb begin
		dll_sync_nxt = {dll_sync_r[1:0], delay_loop_disable};
		fill_nxt = {fill_r[1:0], 1'b1};
		strap_done_nxt = strap_done_r;
		nodll_nxt = nodll_r;
		if (!strap_done_r && fill_r[2] &&
			dll_sync_r[1] == dll_sync_r[2]) begin
			strap_done_nxt = 1'b1;
			nodll_nxt = dll_sync_r[2];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dll_sync_r <= 3'h0;
			fill_r <= 3'h0;
			strap_done_r <= 1'b0;
			nodll_r <= 1'b0;
		end else begin
			dll_sync_r <= dll_sync_nxt;
			fill_r <= fill_nxt;
			strap_done_r <= strap_done_nxt;
			nodll_r <= nodll_nxt;
		end
	end

	// Selects count only on positive edges and not right after own start
	assign wr_go = link.ref_pos_phase && !link.write_port_select_n &&
		!wr_lock_r;
	assign rd_go = link.ref_pos_phase && !link.read_port_select_n &&
		!rd_lock_r;

	always_comb begin
		wr_act_nxt = wr_act_r;
		wr_beat_nxt = wr_beat_r;
		wr_addr_nxt = wr_addr_r;
		wr_lock_nxt = wr_lock_r;
		rd_act_nxt = rd_act_r;
		rd_beat_nxt = rd_beat_r;
		rd_addr_nxt = rd_addr_r;
		rd_lock_nxt = rd_lock_r;
		rd_wait_nxt = rd_wait_r;
		wr_pend_nxt = wr_pend_r;
		wr_paddr_nxt = wr_paddr_r;
		rd_pend_nxt = rd_pend_r;
		rd_paddr_nxt = rd_paddr_r;
		q_nxt = q_r;
		oe_nxt = oe_r;
		vld_nxt = 1'b0;
		if (link.ref_pos_phase) begin
			wr_lock_nxt = wr_go;
			rd_lock_nxt = rd_go;
		end
		// Write burst: beats on four edges, from the second edge after the start
		if (wr_act_r) begin
			wr_beat_nxt = wr_beat_r + 2'h1;
			if (wr_beat_r == 2'h3)
				wr_act_nxt = 1'b0;
		end
		// Beats start one cycle after the start edge, at t+1 and t+2
		if (wr_pend_r) begin
			wr_act_nxt = 1'b1;
			wr_beat_nxt = qrsbp_pkg::BEAT_RST;
			wr_addr_nxt = wr_paddr_r;
		end
		wr_pend_nxt = wr_go;
		if (wr_go)
			wr_paddr_nxt = link.addr;
		// Read burst: four beats, one per edge
		if (rd_act_r) begin
			q_nxt = mem[burst_addr(rd_addr_r, rd_beat_r)];
			oe_nxt = 1'b1;
			vld_nxt = 1'b1;
			rd_beat_nxt = rd_beat_r + 2'h1;
			if (rd_beat_r == 2'h3)
				rd_act_nxt = 1'b0;
		end else if (oe_r && link.ref_pos_phase) begin
			oe_nxt = 1'b0; // Release after the burst ends
		end
		// Latency counts apart from the beats
		// A pending read starts when its wait ends, whether or not a burst is still busy
		if (rd_pend_r) begin
			if (rd_wait_r != 3'h0) begin
				rd_wait_nxt = rd_wait_r - 3'h1;
			end else begin
				rd_pend_nxt = 1'b0;
				rd_act_nxt = 1'b1;
				rd_beat_nxt = qrsbp_pkg::BEAT_RST;
				rd_addr_nxt = rd_paddr_r;
			end
		end
		if (rd_go) begin
			rd_pend_nxt = 1'b1;
			rd_paddr_nxt = link.addr;
			rd_wait_nxt = nodll_r ? qrsbp_pkg::RD_LAT_NODLL - 3'h2 :
				qrsbp_pkg::RD_LAT_DLL - 3'h2;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_act_r <= 1'b0;
			rd_act_r <= 1'b0;
			wr_beat_r <= qrsbp_pkg::BEAT_RST;
			rd_beat_r <= qrsbp_pkg::BEAT_RST;
			wr_addr_r <= qrsbp_pkg::ADDR_RST;
			rd_addr_r <= qrsbp_pkg::ADDR_RST;
			wr_lock_r <= 1'b0;
			rd_lock_r <= 1'b0;
			rd_wait_r <= 3'h0;
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			wr_paddr_r <= qrsbp_pkg::ADDR_RST;
			rd_paddr_r <= qrsbp_pkg::ADDR_RST;
			q_r <= qrsbp_pkg::DATA_RST;
			oe_r <= 1'b0;
			vld_r <= 1'b0;
		end else begin
			// Registers only move on clock edges; a stopped clock holds all
			wr_act_r <= wr_act_nxt;
			rd_act_r <= rd_act_nxt;
			wr_beat_r <= wr_beat_nxt;
			rd_beat_r <= rd_beat_nxt;
			wr_addr_r <= wr_addr_nxt;
			rd_addr_r <= rd_addr_nxt;
			wr_lock_r <= wr_lock_nxt;
			rd_lock_r <= rd_lock_nxt;
			rd_wait_r <= rd_wait_nxt;
			wr_pend_r <= wr_pend_nxt;
			rd_pend_r <= rd_pend_nxt;
			wr_paddr_r <= wr_paddr_nxt;
			rd_paddr_r <= rd_paddr_nxt;
			q_r <= q_nxt;
			oe_r <= oe_nxt;
			vld_r <= vld_nxt;
		end
	end

	// Array has no reset; each beat merges lanes on its own mask
	always_ff @(posedge clock) begin
		if (wr_act_r && link.byte_lane_mask_n != qrsbp_pkg::MASK_NONE)
			mem[burst_addr(wr_addr_r, wr_beat_r)] <= merge(
				mem[burst_addr(wr_addr_r, wr_beat_r)],
				link.write_input_bus,
				link.byte_lane_mask_n);
	end

	assign link.read_output_bus = q_r;
	assign link.read_output_oe = oe_r;
	assign link.read_output_valid = vld_r;
endmodule

// >>> verilog/qrsbp_if.sv
// Link between memory controller and burst SRAM device
`timescale 1ns/1ps
interface qrsbp_if;
	// Command and address, sampled on the positive input reference
	logic read_port_select_n;
	logic write_port_select_n;
	logic [qrsbp_pkg::ADDR_W-1:0] addr;
	// Write data and masks, one beat per data edge
	logic [qrsbp_pkg::DATA_W-1:0] write_input_bus;
	logic [qrsbp_pkg::LANES-1:0] byte_lane_mask_n;
	// Read data with its enable, one beat per data edge
	logic [qrsbp_pkg::DATA_W-1:0] read_output_bus;
	logic read_output_oe;
	logic read_output_valid;
	// Beat phase: high on the positive reference half
	logic ref_pos_phase;
	modport device (
		input read_port_select_n, write_port_select_n, addr,
		input write_input_bus, byte_lane_mask_n, ref_pos_phase,
		output read_output_bus, read_output_oe, read_output_valid
	);
	modport controller (
		output read_port_select_n, write_port_select_n, addr,
		output write_input_bus, byte_lane_mask_n, ref_pos_phase,
		input read_output_bus, read_output_oe, read_output_valid
	);
endinterface

// >>> verilog/qrsbp_pkg.sv
// Constants and types shared by both ends of the burst SRAM port
package qrsbp_pkg;
	localparam int ADDR_W = 8;
	localparam int LANE_W = 9;
	localparam int LANES = 2;
	localparam int DATA_W = LANE_W * LANES;
	localparam int BURST_LEN = 4;
	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [1:0] BEAT_RST = 2'h0;
	localparam logic [LANES-1:0] MASK_NONE = {LANES{1'b1}};
	localparam logic [DATA_W-1:0] DATA_RST = {DATA_W{1'b0}};
	localparam logic [ADDR_W-1:0] ADDR_RST = {ADDR_W{1'b0}};
	// Read latency in data beats (half cycles): 3 with the loop, 2 without
	localparam logic [2:0] RD_LAT_DLL = 3'h3;
	localparam logic [2:0] RD_LAT_NODLL = 3'h2;
	typedef enum logic [1:0] {qrsbp_op_none, qrsbp_op_read, qrsbp_op_write}
		qrsbp_op_type;
endpackage
